/* File: hdl/ssd_front.sv */
// Serial memory front end: edge convention, lane-mode switching, byte FIFO
`timescale 1ns/1ps
module ssd_front #(
    parameter int FIFO_DEPTH = ssd_pkg::SSD_FIFO_DEPTH
) (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic                sck,
    input  wire logic                cs_n,
    input  wire logic                dual_lane_0_in,
    output logic                     dual_lane_0_out,
    output logic                     dual_lane_0_oe,
    input  wire logic                dual_lane_1_in,
    output logic                     dual_lane_1_out,
    output logic                     dual_lane_1_oe,
    input  wire logic                supply_ok,
    output logic                     dual_lane_mode,
    output logic                     rx_valid,
    input  wire logic                rx_ready,
    output ssd_pkg::ssd_rx_word_t    rx_word,
    output logic                     rx_overrun,
    input  wire logic                tx_en,
    input  wire logic                tx_valid,
    input  wire logic [7:0]          tx_data,
    output logic                     tx_ready
);
    import ssd_pkg::*;

    // ****************************************
    // Serial clock edges
    // ****************************************
    logic sck_ff, cs_n_ff, sck_rise, sck_fall, active;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_ff  <= 1'b0;
            cs_n_ff <= 1'b1;
        end else begin
            sck_ff  <= sck;
            cs_n_ff <= cs_n;
        end
    end

    assign sck_rise = sck && !sck_ff;
    assign sck_fall = !sck && sck_ff;
    // Under backup supply the frame is ignored entirely
    assign active   = !cs_n && supply_ok;

    // ****************************************
    // Receive shifter and lane mode
    // ****************************************
    logic [7:0]   rx_sh_ff, nxt_rx_sh;
    logic [3:0]   rx_cnt_ff, nxt_rx_cnt;
    logic         first_ff, nxt_first;
    logic         mode_ff, nxt_mode;
    logic         ovr_ff, nxt_ovr;
    logic         push;
    logic         fifo_in_ready;
    ssd_rx_word_t push_word;
    logic [3:0]   rx_step;
    logic [7:0]   shifted;

    always_comb begin
        nxt_rx_sh  = rx_sh_ff;
        nxt_rx_cnt = rx_cnt_ff;
        nxt_first  = first_ff;
        nxt_mode   = mode_ff;
        nxt_ovr    = ovr_ff;
        push       = 1'b0;
        rx_step    = mode_ff ? SSD_STEP_DUAL : SSD_STEP_SINGLE;
        shifted    = mode_ff ? {rx_sh_ff[5:0], dual_lane_1_in, dual_lane_0_in}
                             : {rx_sh_ff[6:0], dual_lane_0_in};
        push_word.first = first_ff;
        push_word.data  = shifted;
        if (!active) begin
            // Chip select high restarts byte framing
            nxt_rx_cnt = '0;
            nxt_first  = 1'b1;
        end else if (sck_rise) begin
            nxt_rx_sh  = shifted;
            nxt_rx_cnt = rx_cnt_ff + rx_step;
            // Write data only; during read data the lanes carry our output
            if (rx_cnt_ff + rx_step == SSD_BITS_PER_BYTE) begin
                nxt_rx_cnt = '0;
                nxt_first  = 1'b0;
                push       = !tx_en;
                if (first_ff && !mode_ff && shifted == SSD_CMD_ENTER_DUAL) begin
                    nxt_mode = 1'b1;
                end
                // Exit is recognised only at the width in force
                if (first_ff && mode_ff && shifted == SSD_CMD_EXIT_DUAL) begin
                    nxt_mode = 1'b0;
                end
            end
        end
        // Serial link cannot stall, so a full FIFO drops and flags
        if (push && !fifo_in_ready) begin
            nxt_ovr = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_sh_ff  <= '0;
            rx_cnt_ff <= '0;
            first_ff  <= 1'b1;
            mode_ff   <= SSD_MODE_RESET;
            ovr_ff    <= 1'b0;
        end else begin
            rx_sh_ff  <= nxt_rx_sh;
            rx_cnt_ff <= nxt_rx_cnt;
            first_ff  <= nxt_first;
            mode_ff   <= nxt_mode;
            ovr_ff    <= nxt_ovr;
        end
    end

    assign dual_lane_mode = mode_ff;
    assign rx_overrun     = ovr_ff;

    ssd_fifo #(
        .WIDTH (SSD_RX_W),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   (push_word),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (rx_word)
    );

    // ****************************************
    // Transmit shifter and lane drive
    // ****************************************
    logic [7:0] tx_sh_ff, nxt_tx_sh;
    logic [3:0] tx_cnt_ff, nxt_tx_cnt;
    logic       l0_ff, nxt_l0, l1_ff, nxt_l1;
    logic       oe0_ff, nxt_oe0, oe1_ff, nxt_oe1;
    logic       rdy_ff, nxt_rdy;
    logic [7:0] src;

    always_comb begin
        nxt_tx_sh  = tx_sh_ff;
        nxt_tx_cnt = tx_cnt_ff;
        nxt_l0     = l0_ff;
        nxt_l1     = l1_ff;
        nxt_rdy    = 1'b0;
        src        = tx_sh_ff;
        // Drive only read data; command and address phases keep lanes as inputs
        nxt_oe1    = active && tx_en;
        nxt_oe0    = active && tx_en && mode_ff;
        if (!active || !tx_en) begin
            nxt_tx_cnt = '0;
        end else if (sck_fall) begin
            if (tx_cnt_ff == '0) begin
                // Missing data shifts out zeros rather than stalling the host
                src     = tx_valid ? tx_data : 8'h00;
                nxt_rdy = tx_valid;
            end
            nxt_l1 = src[7];
            nxt_l0 = mode_ff ? src[6] : l0_ff;
            if (mode_ff) begin
                nxt_tx_sh  = {src[5:0], 2'h0};
                nxt_tx_cnt = (tx_cnt_ff == '0) ? SSD_BITS_PER_BYTE - SSD_STEP_DUAL
                                               : tx_cnt_ff - SSD_STEP_DUAL;
            end else begin
                nxt_tx_sh  = {src[6:0], 1'h0};
                nxt_tx_cnt = (tx_cnt_ff == '0) ? SSD_BITS_PER_BYTE - SSD_STEP_SINGLE
                                               : tx_cnt_ff - SSD_STEP_SINGLE;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_sh_ff  <= '0;
            tx_cnt_ff <= '0;
            l0_ff     <= 1'b0;
            l1_ff     <= 1'b0;
            oe0_ff    <= 1'b0;
            oe1_ff    <= 1'b0;
            rdy_ff    <= 1'b0;
        end else begin
            tx_sh_ff  <= nxt_tx_sh;
            tx_cnt_ff <= nxt_tx_cnt;
            l0_ff     <= nxt_l0;
            l1_ff     <= nxt_l1;
            oe0_ff    <= nxt_oe0;
            oe1_ff    <= nxt_oe1;
            rdy_ff    <= nxt_rdy;
        end
    end

    assign dual_lane_0_out = l0_ff;
    assign dual_lane_1_out = l1_ff;
    assign dual_lane_0_oe  = oe0_ff;
    assign dual_lane_1_oe  = oe1_ff;
    assign tx_ready        = rdy_ff;
endmodule : ssd_front

/* File: hdl/ssd_pkg.sv */
// Constants and carrier types for the serial memory lane-mode front end
package ssd_pkg;
    // ****************************************
    // Command bytes
    // ****************************************
    localparam logic [7:0] SSD_CMD_ENTER_DUAL = 8'h3B;
    localparam logic [7:0] SSD_CMD_EXIT_DUAL  = 8'hFF;
    // ****************************************
    // Shift geometry and reset values
    // ****************************************
    localparam int         SSD_BYTE_BITS      = 8;
    localparam logic [3:0] SSD_BITS_PER_BYTE  = 4'h8;
    localparam logic [3:0] SSD_STEP_SINGLE    = 4'h1;
    localparam logic [3:0] SSD_STEP_DUAL      = 4'h2;
    localparam logic       SSD_MODE_RESET     = 1'h0;
    localparam int         SSD_FIFO_DEPTH     = 4;

    typedef struct packed {
        logic       first;
        logic [7:0] data;
    } ssd_rx_word_t;

    localparam int SSD_RX_W = $bits(ssd_rx_word_t);
endpackage : ssd_pkg

/* File: hdl/ssd_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module ssd_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ff, nxt_wr, rd_ff, nxt_rd;
    logic [AW:0]      cnt_ff, nxt_cnt;
    logic             push, pop;

    assign in_ready  = (cnt_ff != AW'(0) + (AW+1)'(DEPTH));
    assign out_valid = (cnt_ff != '0);
    assign out_data  = mem_ff[rd_ff];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        nxt_wr  = wr_ff;
        nxt_rd  = rd_ff;
        nxt_cnt = cnt_ff;
        if (push) begin
            nxt_wr = (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + AW'(1);
        end
        if (pop) begin
            nxt_rd = (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + AW'(1);
        end
        if (push && !pop) begin
            nxt_cnt = cnt_ff + (AW+1)'(1);
        end else if (pop && !push) begin
            nxt_cnt = cnt_ff - (AW+1)'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
        end else begin
            wr_ff  <= nxt_wr;
            rd_ff  <= nxt_rd;
            cnt_ff <= nxt_cnt;
        end
    end

    // Storage needs no reset; only the count and pointers define validity
    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wr_ff] <= in_data;
        end
    end
endmodule : ssd_fifo

/* File: sim/ssd_chk.sv */
// Port checks for the lane-mode front end
`timescale 1ns/1ps
module ssd_chk #(
    parameter int FIFO_DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic supply_ok,
    input wire logic tx_en,
    input wire logic dual_lane_0_oe,
    input wire logic dual_lane_1_oe,
    input wire logic dual_lane_1_out,
    input wire logic dual_lane_mode,
    input wire logic tx_ready
);
    logic sck_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_ff <= 1'h0;
        end else begin
            sck_ff <= sck;
        end
    end
    wire rise = sck & ~sck_ff;
    wire fall = ~sck & sck_ff;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ****
    // Edge and lane checks
    // ****
    sequence s_pulse;
        tx_ready ##1 !tx_ready;
    endsequence
    a_mode_on_rise: assert property ($changed(dual_lane_mode) |->
        $past(rise & ~cs_n & supply_ok)) else $error("mode moved off a rise");
    a_mode_holds: assert property (cs_n |=> $stable(dual_lane_mode))
        else $error("mode moved while idle");
    a_out_on_fall: assert property ($changed(dual_lane_1_out) && $past(dual_lane_1_oe)
        && dual_lane_1_oe |-> $past(fall)) else $error("lane moved off a fall");
    a_ready_on_fall: assert property (tx_ready |-> $past(fall & ~cs_n & tx_en))
        else $error("ready without a fall");
    a_ready_pulse: assert property ($rose(tx_ready) |-> s_pulse)
        else $error("ready too long");
    a_lane1_drive: assert property (dual_lane_1_oe |-> $past(~cs_n & supply_ok & tx_en))
        else $error("lane 1 driven outside read");
    a_lane0_drive: assert property (dual_lane_0_oe |-> $past(dual_lane_mode & tx_en))
        else $error("lane 0 driven outside dual read");
    a_supply_low: assert property (!supply_ok |=> !dual_lane_0_oe && !dual_lane_1_oe)
        else $error("lanes driven on backup");
endmodule : ssd_chk

/* File: sim/ssd_host.sv */
// Serial bus master model: clock, select and both data lanes
`timescale 1ns/1ps
module ssd_host (
    input  wire logic clk,
    input  wire logic q0,
    input  wire logic q1,
    output logic      sck,
    output logic      cs_n,
    output logic      d0,
    output logic      d1,
    output logic      oe0,
    output logic      oe1
);
    logic dual;
    initial begin
        {sck, d0, d1, oe0, oe1, dual} = 6'h00;
        cs_n = 1'h1;
    end
    // Select held low over the whole sequence
    task automatic open_frame();
        cs_n = 1'h0;
        repeat (2) @(negedge clk);
    endtask : open_frame
    task automatic close_frame();
        sck = 1'h0;
        {oe0, oe1} = 2'h0;
        repeat (2) @(negedge clk);
        cs_n = 1'h1;
        repeat (3) @(negedge clk);
    endtask : close_frame
    // Lane width follows our view of the mode, exit included
    task automatic xfer(input logic [7:0] b, input logic rd, output logic [7:0] r);
        r = 8'h00;
        oe0 = !rd;
        oe1 = !rd && dual;
        for (int i = 0; i < (dual ? 4 : 8); i++) begin
            sck = 1'h0;
            d1 = dual ? b[7-2*i] : d1;
            d0 = dual ? b[6-2*i] : b[7-i];
            repeat (2) @(negedge clk);
            sck = 1'h1;
            r = dual ? {r[5:0], q1, q0} : {r[6:0], q1};
            repeat (2) @(negedge clk);
        end
    endtask : xfer
endmodule : ssd_host

/* File: sim/tb.sv */
// Self-checking bench for the lane-mode front end
`timescale 1ns/1ps
module tb;
    import ssd_pkg::*;
    logic         clk, rst_n, sck, cs_n, d0, d1, oe0, oe1, o0, o1, e0, e1, ok;
    logic         mode, rx_valid, rx_ready, ovr, tx_en, tx_valid, tx_ready;
    logic [7:0]   tx_data, r;
    ssd_rx_word_t rx_word;
    int           fails = 0;
    int           checks = 0;
    int           rdy_n = 0;
    // Released lanes show the inverse of the last host value
    wire          l0 = oe0 ? d0 : e0 ? o0 : ~d0;
    wire          l1 = oe1 ? d1 : e1 ? o1 : ~d1;
    ssd_front #(.FIFO_DEPTH(4)) dut_u (.clk(clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n),
        .dual_lane_0_in(l0), .dual_lane_0_out(o0), .dual_lane_0_oe(e0), .dual_lane_1_in(l1),
        .dual_lane_1_out(o1), .dual_lane_1_oe(e1), .supply_ok(ok), .dual_lane_mode(mode),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_word(rx_word), .rx_overrun(ovr),
        .tx_en(tx_en), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
    ssd_host h_u (.clk(clk), .q0(l0), .q1(l1), .sck(sck), .cs_n(cs_n), .d0(d0), .d1(d1),
        .oe0(oe0), .oe1(oe1));
    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end
    // Counted away from the launching edge so the pulse is settled
    always @(negedge clk) begin
        if (tx_ready === 1'b1) begin
            rdy_n++;
        end
    end
    // ****
    // Shared tasks
    // ****
    task automatic end_of_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic c, input string m);
        checks++;
        if (c !== 1'b1) begin
            fails++;
            $display("FAIL %0t %s", $time, m);
        end
    endtask : chk
    task automatic pop(input ssd_rx_word_t e);
        int k;
        for (k = 0; k < 40 && rx_valid !== 1'b1; k++) @(negedge clk);
        if (k == 40) begin
            fails++;
            $display("FAIL %0t no received byte", $time);
            end_of_test();
        end else begin
            chk(rx_word === e, "rx word");
            rx_ready = 1'h1;
            @(negedge clk);
            rx_ready = 1'h0;
        end
    endtask : pop
    task automatic frame1(input logic [7:0] b);
        h_u.open_frame();
        h_u.xfer(b, 1'h0, r);
        h_u.close_frame();
    endtask : frame1
    task automatic rd(input logic [7:0] c);
        h_u.open_frame();
        h_u.xfer(c, 1'h0, r);
        tx_en = 1'h1;
        h_u.xfer(8'h00, 1'h1, r);
        tx_en = 1'h0;
        h_u.close_frame();
    endtask : rd
    // ****
    // Scenarios
    // ****
    task automatic t_enter();
        chk(mode === 1'b0 && e0 === 1'b0 && e1 === 1'b0, "reset state");
        frame1(8'h3A);
        chk(mode === 1'b0, "near-miss byte switched mode");
        pop({1'b1, 8'h3A});
        frame1(8'h3B);
        h_u.dual = 1'h1;
        chk(mode === 1'b1, "enter failed");
        pop({1'b1, 8'h3B});
        $display("enter done");
    endtask : t_enter
    task automatic t_dual_read();
        tx_data = 8'h96;
        rd(8'hA5);
        chk(r === 8'h96, "dual read data");
        chk(rdy_n == 1, "dual read byte count");
        chk(mode === 1'b1, "mode lost across frames");
        pop({1'b1, 8'hA5});
        $display("dual read done");
    endtask : t_dual_read
    task automatic t_exit();
        frame1(8'hFF);
        h_u.dual = 1'h0;
        chk(mode === 1'b0, "exit failed");
        pop({1'b1, 8'hFF});
        tx_data = 8'hA5;
        rd(8'h03);
        chk(r === 8'hA5, "single read data");
        chk(rdy_n == 2, "single read byte count");
        pop({1'b1, 8'h03});
        $display("exit done");
    endtask : t_exit
    task automatic t_supply();
        ok = 1'h0;
        frame1(8'h3B);
        rd(8'h03);
        chk(mode === 1'b0 && rx_valid === 1'b0, "access taken on backup");
        chk(rdy_n == 2, "read served on backup");
        ok = 1'h1;
        $display("supply done");
    endtask : t_supply
    // Host has lost the mode, so it always sends the exit at dual width
    task automatic t_restart();
        frame1(8'h3B);
        chk(mode === 1'b1, "enter before restart");
        pop({1'b1, 8'h3B});
        for (int i = 0; i < 2; i++) begin
            h_u.dual = 1'h1;
            frame1(8'hFF);
            h_u.dual = 1'h0;
            chk(mode === 1'b0, "recovery missed the mode");
        end
        pop({1'b1, 8'hFF});
        chk(rx_valid === 1'b0, "half byte pushed");
        frame1(8'h3B);
        chk(mode === 1'b1, "enter before reset");
        rst_n = 1'h0;
        repeat (2) @(negedge clk);
        rst_n = 1'h1;
        @(negedge clk);
        chk(mode === 1'b0 && rx_valid === 1'b0, "mode kept over reset");
        $display("restart done");
    endtask : t_restart
    task automatic t_fifo();
        logic [7:0] b;
        h_u.open_frame();
        for (int i = 0; i < 5; i++) begin
            chk(ovr === 1'b0, "early overrun");
            b = 8'h10 + 8'(i);
            h_u.xfer(b, 1'h0, r);
        end
        h_u.close_frame();
        chk(ovr === 1'b1, "no overrun when full");
        for (int i = 0; i < 4; i++) begin
            b = 8'h10 + 8'(i);
            pop({i == 0, b});
        end
        chk(rx_valid === 1'b0, "buffer not empty");
        $display("fifo done");
    endtask : t_fifo
    initial begin
        {rst_n, rx_ready, tx_en} = 3'h0;
        {ok, tx_valid} = 2'h3;
        tx_data = 8'h00;
        repeat (12) @(negedge clk);
        rst_n = 1'h1;
        @(negedge clk);
        t_enter();
        t_dual_read();
        t_exit();
        t_supply();
        t_restart();
        t_fifo();
        end_of_test();
    end
endmodule : tb
bind ssd_front ssd_chk #(.FIFO_DEPTH(FIFO_DEPTH)) chk_u (.clk(clk), .rst_n(rst_n), .sck(sck),
    .cs_n(cs_n), .supply_ok(supply_ok), .tx_en(tx_en), .dual_lane_0_oe(dual_lane_0_oe),
    .dual_lane_1_oe(dual_lane_1_oe), .dual_lane_1_out(dual_lane_1_out),
    .dual_lane_mode(dual_lane_mode), .tx_ready(tx_ready));
